/* File: include/mscf_map.svh */
// Notes on behaviour
// - every enabled channel gets its own message in each output string
// - first variant replaces the start-of-text byte with a channel byte
// - first variant channel byte is 01 to 04 for scales, 05 for sum
// - weight is six ascii digits, no sign or point, leading zeros blanked
// - tare is six ascii digits with no sign and no decimal point
// - each message has a carriage return after the tare field, followed by the checksum byte when enabled
// - optional checksum is two's complement of low 7 bits of byte sum
// - checksum only offered on serial ports one to four
// - second variant always leads every message with start-of-text
// - second variant puts channel 1..5 in status_byte_third bits 2:0
// - status_byte_first: point position, build code, bit 5 one, bit 6 zero
// - status_byte_second: net, sign, motion, kg, power-up, bit 5 one
// - status_byte_second bit 2 set when over capacity or under zero
// - status_byte_third: print request bit 3, expand bit 4, bit 5 one
`ifndef MSCF_MAP_SVH
`define MSCF_MAP_SVH
`define MSCF_NUM_CH 5
`define MSCF_CH_W 3
`define MSCF_MSG_LEN 18
`define MSCF_IDX_W 5
`define MSCF_IDX_LEAD 5'h00
`define MSCF_IDX_STAT_FIRST 5'h01
`define MSCF_IDX_STAT_SECOND 5'h02
`define MSCF_IDX_STAT_THIRD 5'h03
`define MSCF_IDX_WT0 5'h04
`define MSCF_IDX_TR0 5'h0A
`define MSCF_IDX_CR 5'h10
`define MSCF_IDX_CKS 5'h11
`define MSCF_BYTE_STX 8'h02
`define MSCF_BYTE_CR 8'h0D
`define MSCF_BYTE_SPACE 8'h20
`define MSCF_BYTE_ZERO 8'h30
`define MSCF_CKS_MASK 7'h7F
`define MSCF_DIGITS 6
`endif

/* File: include/mscf_pkg.sv */
package mscf_pkg;
  // per-channel weighing state as presented by the terminal
  typedef struct packed {
    logic [23:0] weight_bcd;
    logic [23:0] tare_bcd;
    logic [2:0] point_pos;
    logic [1:0] build_code;
    logic net_mode;
    logic negative;
    logic over_cap;
    logic under_zero;
    logic motion;
    logic kg_units;
    logic power_up;
    logic print_req;
    logic expand_x10;
  } mscf_scale_t;

  typedef enum logic {
    MSCF_VARIANT_ONE = 1'b0,
    MSCF_VARIANT_TWO = 1'b1
  } mscf_variant_t;

  typedef enum logic [2:0] {
    MSCF_S_IDLE = 3'b001,
    MSCF_S_LOAD = 3'b010,
    MSCF_S_SEND = 3'b100
  } mscf_state_t;
endpackage

/* File: core/mscf_ascii6.sv */
`timescale 1ns/10ps
`include "mscf_map.svh"
// turns six bcd digits into ascii, optionally blanking leading zeros
module mscf_ascii6 (
  input wire logic [23:0] bcd,
  input wire logic blank_lead,
  output logic [47:0] ascii
);
  // walk from the most significant digit; the last digit is never blanked
  always_comb begin
    logic leading;
    leading = blank_lead;
    ascii = 48'h0;
    for (int i = `MSCF_DIGITS - 1; i >= 0; i--) begin
      if (leading && (bcd[i*4 +: 4] == 4'h0) && (i != 0)) begin
        ascii[i*8 +: 8] = `MSCF_BYTE_SPACE;
      end else begin
        leading = 1'b0;
        ascii[i*8 +: 8] = `MSCF_BYTE_ZERO | {4'h0, bcd[i*4 +: 4]};
      end
    end
  end
endmodule

/* File: core/mscf_framer.sv */
`timescale 1ns/10ps
`include "mscf_map.svh"
module mscf_framer
  import mscf_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic out_enable,
  input wire mscf_variant_t variant,
  input wire logic [`MSCF_NUM_CH-1:0] chan_enable,
  input wire logic checksum_en,
  input wire logic serial_ports_one_to_four,
  input wire mscf_scale_t [`MSCF_NUM_CH-1:0] scale_in,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic [`MSCF_CH_W-1:0] tx_chan,
  output logic busy
);
  // next enabled channel at or after start; msb flags that one was found
  function automatic logic [`MSCF_CH_W:0] find_chan(input logic [`MSCF_NUM_CH-1:0] mask,
                                                    input logic [`MSCF_CH_W:0] start);
    logic [`MSCF_CH_W:0] res;
    res = '0;
    for (int i = `MSCF_NUM_CH - 1; i >= 0; i--) begin
      if (mask[i] && (i >= int'(start))) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction

  mscf_state_t state_reg, state_next;
  logic [`MSCF_IDX_W-1:0] idx_reg, idx_next;
  logic [`MSCF_CH_W-1:0] chan_reg, chan_next;
  mscf_scale_t snap_reg, snap_next;
  mscf_variant_t var_reg, var_next;
  logic cks_reg, cks_next;
  logic [6:0] sum_reg, sum_next;
  logic [7:0] tx_data_reg, tx_data_next;
  logic tx_valid_reg, tx_valid_next;
  logic busy_reg, busy_next;
  logic [47:0] wt_ascii;
  logic [47:0] tr_ascii;
  logic [7:0] cur_byte;
  logic [7:0] chan_code;
  logic [`MSCF_IDX_W-1:0] last_idx;
  logic [`MSCF_CH_W:0] first_hit;
  logic [`MSCF_CH_W:0] after_hit;

  // weight blanks leading zeros, tare keeps them
  mscf_ascii6 u_weight (
    .bcd(snap_reg.weight_bcd),
    .blank_lead(1'b1),
    .ascii(wt_ascii)
  );
  mscf_ascii6 u_tare (
    .bcd(snap_reg.tare_bcd),
    .blank_lead(1'b0),
    .ascii(tr_ascii)
  );

  // byte of the current message selected by the index
  always_comb begin
    chan_code = {5'h00, chan_reg + 3'h1};
    last_idx = cks_reg ? `MSCF_IDX_CKS : `MSCF_IDX_CR;
    first_hit = find_chan(chan_enable, 4'h0);
    after_hit = find_chan(chan_enable, {1'b0, chan_reg} + 4'h1);
    cur_byte = 8'h00;
    if (idx_reg == `MSCF_IDX_LEAD) begin
      cur_byte = (var_reg == MSCF_VARIANT_ONE) ? chan_code : `MSCF_BYTE_STX;
    end else if (idx_reg == `MSCF_IDX_STAT_FIRST) begin
      cur_byte = {3'b001, snap_reg.build_code, snap_reg.point_pos};
    end else if (idx_reg == `MSCF_IDX_STAT_SECOND) begin
      cur_byte = {1'b0, snap_reg.power_up, 1'b1, snap_reg.kg_units, snap_reg.motion,
                  snap_reg.over_cap | snap_reg.under_zero,
                  snap_reg.negative, snap_reg.net_mode};
    end else if (idx_reg == `MSCF_IDX_STAT_THIRD) begin
      cur_byte = {3'b001, snap_reg.expand_x10, snap_reg.print_req,
                  (var_reg == MSCF_VARIANT_TWO) ? chan_code[2:0] : 3'h0};
    end else if (idx_reg < `MSCF_IDX_TR0) begin
      cur_byte = wt_ascii[8*(5 - (idx_reg - `MSCF_IDX_WT0)) +: 8];
    end else if (idx_reg < `MSCF_IDX_CR) begin
      cur_byte = tr_ascii[8*(5 - (idx_reg - `MSCF_IDX_TR0)) +: 8];
    end else if (idx_reg == `MSCF_IDX_CR) begin
      cur_byte = `MSCF_BYTE_CR;
    end else begin
      cur_byte = {1'b0, (~sum_reg + 7'h01) & `MSCF_CKS_MASK};
    end
  end

  // sequencing: one message per enabled channel, ascending, then wrap
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    chan_next = chan_reg;
    snap_next = snap_reg;
    var_next = var_reg;
    cks_next = cks_reg;
    sum_next = sum_reg;
    tx_data_next = tx_data_reg;
    tx_valid_next = tx_valid_reg;
    busy_next = busy_reg;
    unique case (state_reg)
      MSCF_S_IDLE: begin
        busy_next = 1'b0;
        if (out_enable && first_hit[`MSCF_CH_W]) begin
          chan_next = first_hit[`MSCF_CH_W-1:0];
          state_next = MSCF_S_LOAD;
          busy_next = 1'b1;
        end
      end
      MSCF_S_LOAD: begin
        // snapshot so a message never mixes two samples
        snap_next = scale_in[chan_reg];
        var_next = variant;
        cks_next = checksum_en & serial_ports_one_to_four;
        idx_next = `MSCF_IDX_LEAD;
        sum_next = 7'h00;
        state_next = MSCF_S_SEND;
      end
      MSCF_S_SEND: begin
        if (!tx_valid_reg) begin
          tx_data_next = cur_byte;
          tx_valid_next = 1'b1;
        end else if (tx_ready) begin
          tx_valid_next = 1'b0;
          sum_next = sum_reg + tx_data_reg[6:0];
          if (idx_reg != last_idx) begin
            idx_next = idx_reg + 5'h01;
          end else if (!out_enable) begin
            state_next = MSCF_S_IDLE; // string stops at a message boundary
          end else if (after_hit[`MSCF_CH_W]) begin
            chan_next = after_hit[`MSCF_CH_W-1:0];
            state_next = MSCF_S_LOAD;
          end else if (first_hit[`MSCF_CH_W]) begin
            chan_next = first_hit[`MSCF_CH_W-1:0];
            state_next = MSCF_S_LOAD;
          end else begin
            state_next = MSCF_S_IDLE;
          end
        end
      end
      default: begin
        state_next = MSCF_S_IDLE;
        tx_valid_next = 1'b0;
      end
    endcase
  end

  // registers of the framer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= MSCF_S_IDLE;
      idx_reg <= '0;
      chan_reg <= '0;
      snap_reg <= '0;
      var_reg <= MSCF_VARIANT_ONE;
      cks_reg <= 1'b0;
      sum_reg <= 7'h00;
      tx_data_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      chan_reg <= chan_next;
      snap_reg <= snap_next;
      var_reg <= var_next;
      cks_reg <= cks_next;
      sum_reg <= sum_next;
      tx_data_reg <= tx_data_next;
      tx_valid_reg <= tx_valid_next;
      busy_reg <= busy_next;
    end
  end

  assign tx_data = tx_data_reg;
  assign tx_valid = tx_valid_reg;
  assign tx_chan = chan_reg;
  assign busy = busy_reg;
endmodule

/* File: tb/mscf_framer_properties.sv */
`timescale 1ns/10ps
module mscf_framer_properties
  import mscf_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire mscf_variant_t variant,
  input wire logic [4:0] chan_enable,
  input wire logic checksum_en,
  input wire logic serial_ports_one_to_four,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic [2:0] tx_chan,
  input wire logic busy
);
  logic [4:0] pos_reg;
  logic [4:0] pos_next;
  // byte slot in the message; assumes config is left alone while busy
  always_comb begin
    pos_next = pos_reg + 5'(tx_valid && tx_ready);
    if (!busy || pos_next == ((checksum_en && serial_ports_one_to_four) ? 5'h12 : 5'h11)) pos_next = 5'h00;
  end
  // slot counter register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) pos_reg <= 5'h00;
    else pos_reg <= pos_next;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  byte_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("byte moved while stalled");
  lead_byte_a: assert property (
    tx_valid && pos_reg == 5'h00 |-> tx_data == (variant == MSCF_VARIANT_TWO ? 8'h02 : 8'(tx_chan) + 8'h01))
    else $error("bad lead byte");
  status_first_a: assert property (tx_valid && pos_reg == 5'h01 |-> tx_data[7:5] == 3'b001)
    else $error("bad first status");
  status_second_a: assert property (tx_valid && pos_reg == 5'h02 |-> tx_data[5] && !tx_data[7])
    else $error("bad second status");
  status_third_a: assert property (tx_valid && pos_reg == 5'h03 |-> tx_data[7:5] == 3'b001 &&
    tx_data[2:0] == (variant == MSCF_VARIANT_TWO ? tx_chan + 3'h1 : 3'h0)) else $error("bad third status");
  digit_field_a: assert property (
    tx_valid && pos_reg inside {[5'h04:5'h0F]} |-> tx_data inside {8'h20, [8'h30:8'h39]})
    else $error("bad digit");
  end_byte_a: assert property (tx_valid && pos_reg == 5'h10 |-> tx_data == 8'h0D)
    else $error("missing carriage return");
  cks_top_a: assert property (tx_valid && pos_reg == 5'h11 |-> !tx_data[7])
    else $error("checksum top bit set");
  chan_enabled_a: assert property (tx_valid |-> chan_enable[tx_chan])
    else $error("disabled channel sent");
endmodule

/* File: tb/mscf_sink.sv */
`timescale 1ns/10ps
// display side byte sink; slow mode takes one byte in four cycles at best
module mscf_sink (
  input wire logic clock,
  input wire logic rstn,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] q[$];
  logic [1:0] cnt = 2'h0;
  // ready moves off the sampling edge so the take is never a race
  always @(negedge clock) begin
    cnt <= cnt + 2'h1;
    tx_ready <= !slow || cnt == 2'h3;
  end
  // a byte counts only where both sides agree at the edge
  always @(posedge clock) if (rstn && tx_valid && tx_ready) q.push_back(tx_data);
endmodule

/* File: tb/mscf_framer_tb.sv */
`timescale 1ns/10ps
module mscf_framer_tb
  import mscf_pkg::*;
;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic out_enable = 1'b0;
  logic checksum_en = 1'b0;
  logic serial_ports_one_to_four = 1'b0;
  logic slow = 1'b0;
  mscf_variant_t variant = MSCF_VARIANT_ONE;
  logic [4:0] chan_enable = 5'h00;
  mscf_scale_t [4:0] scale_in;
  logic tx_ready, tx_valid, busy;
  logic [7:0] tx_data;
  logic [2:0] tx_chan;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  mscf_framer u_mscf_framer (.clock, .rstn, .out_enable, .variant, .chan_enable, .checksum_en,
    .serial_ports_one_to_four, .scale_in, .tx_ready, .tx_data, .tx_valid, .tx_chan, .busy);
  mscf_sink u_mscf_sink (.clock, .rstn, .slow, .tx_valid, .tx_data, .tx_ready);
  initial forever #10 clock = ~clock;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // stream n messages, stop at a message end, then rebuild every byte of the first n
  task automatic run(mscf_variant_t v, logic [4:0] ce, logic ck, logic sp, logic sl, int n);
    int len, m, c, p;
    logic [7:0] e, sum;
    logic [3:0] d;
    logic lead;
    mscf_scale_t s;
    @(negedge clock);
    u_mscf_sink.q.delete();
    variant = v;
    chan_enable = ce;
    checksum_en = ck;
    serial_ports_one_to_four = sp;
    slow = sl;
    out_enable = 1'b1;
    len = (ck && sp) ? 18 : 17;
    // polled on the falling edge so the queue is looked at once it has settled
    while (u_mscf_sink.q.size() < n * len) @(negedge clock);
    @(negedge clock);
    out_enable = 1'b0;
    while (busy) @(negedge clock);
    @(negedge clock);
    check(8'(u_mscf_sink.q.size() % len), 8'h00);
    c = -1;
    for (m = 0; m < n; m++) begin
      do c = (c + 1) % 5; while (!ce[c]);
      s = scale_in[c];
      sum = 8'h00;
      lead = 1'b1;
      for (p = 0; p < len; p++) begin
        case (p)
          0: e = v ? 8'h02 : 8'(c + 1);
          1: e = {3'b001, s.build_code, s.point_pos};
          2: e = {1'b0, s.power_up, 1'b1, s.kg_units, s.motion, s.over_cap | s.under_zero, s.negative, s.net_mode};
          3: e = {3'b001, s.expand_x10, s.print_req, v ? 3'(c + 1) : 3'h0};
          16: e = 8'h0D;
          17: e = {1'b0, 7'(-sum)};
          default: begin
            d = (p < 10) ? s.weight_bcd[4 * (9 - p) +: 4] : s.tare_bcd[4 * (15 - p) +: 4];
            lead = lead && p < 9 && d == 4'h0;
            e = lead ? 8'h20 : {4'h3, d};
          end
        endcase
        sum = sum + {1'b0, e[6:0]};
        check(u_mscf_sink.q[m * len + p], e);
      end
    end
    // messages sent after the stop request still advance the channel order
    for (m = n; m < u_mscf_sink.q.size() / len; m++) begin
      do c = (c + 1) % 5; while (!ce[c]);
    end
    check({5'h00, tx_chan}, 8'(c));
  endtask
  // all channels, first variant, checksum on a serial port, fast sink
  task automatic scen_all_first();
    run(MSCF_VARIANT_ONE, 5'h1F, 1'b1, 1'b1, 1'b0, 10);
  endtask
  // second variant with the sum channel set up, stalling sink
  task automatic scen_second_sum();
    run(MSCF_VARIANT_TWO, 5'h15, 1'b0, 1'b0, 1'b1, 6);
  endtask
  // checksum asked for on a non-serial link must not appear
  task automatic scen_no_serial();
    run(MSCF_VARIANT_ONE, 5'h06, 1'b1, 1'b0, 1'b1, 4);
  endtask
  // watchdog well above the three runs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  // main sequence; channel 4 weighs zero to hit the case of five blanks and a final zero
  initial begin
    for (int i = 0; i < 5; i++)
      scale_in[i] = {(i == 4) ? 24'h000000 : 24'h100000 >> (4 * i), 20'h00050, 4'(i), 3'(i + 3), 2'(i),
        9'(9'h0A5 >> i)};
    repeat (5) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    check({6'h00, tx_valid, busy}, 8'h00);
    scen_all_first();
    scen_second_sum();
    scen_no_serial();
    summarize();
  end
endmodule
bind mscf_framer mscf_framer_properties u_mscf_framer_properties (.clock, .rstn, .variant, .chan_enable,
  .checksum_en, .serial_ports_one_to_four, .tx_ready, .tx_data, .tx_valid, .tx_chan, .busy);
